// File: core/srw_pkg.sv
package srw_pkg;
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned CLK_NS           = 20;
    // Hold time, nominal figure, lies inside 140..280 ms
    localparam int unsigned HOLD_MS          = 200;
    localparam int unsigned HOLD_CYC_DFLT    = HOLD_MS * (CLK_HZ / 1000);
    // Watchdog timeout, nominal 1.6 s, lies inside 1.12..2.40 s
    localparam int unsigned WDT_MS           = 1600;
    localparam int unsigned WDT_CYC_DFLT     = WDT_MS * (CLK_HZ / 1000);
    // Supply fall to reset delay
    localparam int unsigned SUP_DLY_NS       = 20_000;
    localparam int unsigned SUP_DLY_CYC_DFLT = SUP_DLY_NS / CLK_NS;
    // Manual reset minimum valid low width (least time, round up)
    localparam int unsigned MR_MIN_NS        = 1000;
    localparam int unsigned MR_MIN_CYC       = (MR_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W            = 28;
    localparam int unsigned MR_W             = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 28'h0000000;
    localparam logic [MR_W-1:0]  MR_ZERO     = 8'h00;
    localparam logic [1:0]       SYNC_RST    = 2'h3;
endpackage : srw_pkg

// File: core/srw_supervisor.sv
`timescale 1ns/1ps
module srw_supervisor #(
    parameter bit          MR_EN       = 1'b1,
    parameter int unsigned HOLD_CYC    = srw_pkg::HOLD_CYC_DFLT,
    parameter int unsigned WDT_CYC     = srw_pkg::WDT_CYC_DFLT,
    parameter int unsigned SUP_DLY_CYC = srw_pkg::SUP_DLY_CYC_DFLT
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic supply_low,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick_in,
    input  wire logic watchdog_kick_oe_in,
    output logic      watchdog_kick_out,
    output logic      watchdog_kick_oe,
    output logic      reset_n,
    output logic      reset_hi
);
    import srw_pkg::*;

    typedef enum logic [1:0] {
        SRW_RUN  = 2'b00,
        SRW_HOLD = 2'b01,
        SRW_ACT  = 2'b10
    } srw_state_e;

    srw_state_e       state;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wdt_cnt;
    logic [CNT_W-1:0] sup_cnt;
    logic [MR_W-1:0]  mr_cnt;
    logic [1:0]       mr_sync;
    logic [1:0]       kick_sync;
    logic             kick_prev;
    logic             sup_low_q;
    logic             mr_act;
    logic             wdt_fire;
    logic             cause;
    logic             kick_eff;
    logic             kick_edge;

    function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] v);
        cnt_inc = v + 28'h0000001;
    endfunction : cnt_inc

    // Kick line: an undriven pin reads the internal driver's level
    assign kick_eff  = watchdog_kick_oe_in ? watchdog_kick_in : watchdog_kick_out;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mr_sync   <= SYNC_RST;
            kick_sync <= 2'h0;
            kick_prev <= 1'b0;
        end else begin
            mr_sync   <= {mr_sync[0], manual_reset_n};
            kick_sync <= {kick_sync[0], kick_eff};
            kick_prev <= kick_sync[1];
        end
    end

    // 50 ns at 20 ns clock is two or more samples, so any valid pulse is caught
    assign kick_edge = kick_sync[1] ^ kick_prev;

    // Supply fall filter: short dips stay invisible
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sup_cnt   <= CNT_ZERO;
            sup_low_q <= 1'b1;
        end else if (!supply_low) begin
            sup_cnt   <= CNT_ZERO;
            sup_low_q <= 1'b0;
        end else if (sup_cnt >= CNT_W'(SUP_DLY_CYC - 1)) begin
            sup_low_q <= 1'b1;
        end else begin
            sup_cnt   <= cnt_inc(sup_cnt);
        end
    end

    // Glitch filter: low must persist MR_MIN_CYC samples
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mr_cnt <= MR_ZERO;
            mr_act <= 1'b0;
        end else if (!MR_EN || mr_sync[1]) begin
            mr_cnt <= MR_ZERO;
            mr_act <= 1'b0;
        end else if (mr_cnt >= MR_W'(MR_MIN_CYC - 1)) begin
            mr_act <= 1'b1;
        end else begin
            mr_cnt <= mr_cnt + 8'h01;
        end
    end

    assign cause = sup_low_q | mr_act;

    // Watchdog timer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wdt_cnt  <= CNT_ZERO;
            wdt_fire <= 1'b0;
        end else if (state != SRW_RUN || cause || kick_edge) begin
            wdt_cnt  <= CNT_ZERO;
            wdt_fire <= 1'b0;
        end else if (wdt_cnt >= CNT_W'(WDT_CYC - 1)) begin
            wdt_cnt  <= CNT_ZERO;
            wdt_fire <= 1'b1;
        end else begin
            wdt_cnt  <= cnt_inc(wdt_cnt);
            wdt_fire <= 1'b0;
        end
    end

    // Internal kick driver, high from 4 counts before the last eighth of the period
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_kick_out <= 1'b0;
            watchdog_kick_oe  <= 1'b0;
        end else begin
            watchdog_kick_oe  <= ~watchdog_kick_oe_in;
            watchdog_kick_out <= (wdt_cnt >= CNT_W'((WDT_CYC / 8) * 7 - 4));
        end
    end

    // Reset sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state    <= SRW_ACT;
            hold_cnt <= CNT_ZERO;
        end else begin
            case (state)
                SRW_RUN: begin
                    hold_cnt <= CNT_ZERO;
                    if (cause) begin
                        state <= SRW_ACT;
                    end else if (wdt_fire) begin
                        state <= SRW_HOLD;
                    end
                end
                SRW_ACT: begin
                    hold_cnt <= CNT_ZERO;
                    if (!cause) begin
                        state <= SRW_HOLD;
                    end
                end
                SRW_HOLD: begin
                    if (cause) begin
                        state    <= SRW_ACT;
                        hold_cnt <= CNT_ZERO;
                    end else if (hold_cnt >= CNT_W'(HOLD_CYC - 1)) begin
                        state    <= SRW_RUN;
                        hold_cnt <= CNT_ZERO;
                    end else begin
                        hold_cnt <= cnt_inc(hold_cnt);
                    end
                end
                default: begin
                    state    <= SRW_ACT;
                    hold_cnt <= CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reset_n  <= 1'b0;
            reset_hi <= 1'b1;
        end else begin
            reset_n  <= (state == SRW_RUN) && !cause && !wdt_fire;
            reset_hi <= !((state == SRW_RUN) && !cause && !wdt_fire);
        end
    end

    a_out_inverse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_hi == !reset_n) else $error("reset outputs not inverse");

    a_supply_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sup_low_q |=> !reset_n) else $error("reset released during low supply");

    sequence s_wdt_pulse;
        wdt_fire ##1 (state == SRW_HOLD);
    endsequence

    a_wdt_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (wdt_fire && !cause && state == SRW_RUN) |-> s_wdt_pulse) else $error("watchdog pulse missing");

    a_wdt_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state != SRW_RUN) |=> (wdt_cnt == CNT_ZERO)) else $error("watchdog counts in reset");

    a_kick_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        kick_edge |=> (wdt_cnt == CNT_ZERO)) else $error("kick edge did not clear timer");

    a_mr_filter: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(mr_act) |-> ($past(mr_cnt) == MR_W'(MR_MIN_CYC - 1)))
        else $error("manual reset accepted too early");

    a_hold_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_HOLD && !cause && hold_cnt == CNT_W'(HOLD_CYC - 1)) |=> (state == SRW_RUN))
        else $error("hold did not end on time");

    a_brownout_restart: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_HOLD && cause) |=> (state == SRW_ACT && hold_cnt == CNT_ZERO))
        else $error("hold not restarted by cause");

    a_sup_delay: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(sup_low_q) |-> $past(supply_low, 1)) else $error("supply reset without low supply");

    // Hold phase entry: cause gone while actively held
    sequence s_cause_gone;
        (state == SRW_ACT) && !cause;
    endsequence

    sequence s_enter_hold;
        (state == SRW_HOLD) && (hold_cnt == CNT_ZERO);
    endsequence

    a_hold_entry: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_cause_gone |=> s_enter_hold)
        else $error("hold phase not entered");

    a_hold_counts: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_HOLD && !cause && hold_cnt < CNT_W'(HOLD_CYC - 1)) |=> (hold_cnt == cnt_inc($past(hold_cnt))))
        else $error("hold counter skipped");

    a_run_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_RUN && !cause && !wdt_fire) |=> reset_n)
        else $error("reset not released in run");

    a_held_not_run: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state != SRW_RUN) |=> !reset_n)
        else $error("reset released outside run");

    // Any live cause must park the sequencer in the active state
    a_cause_act: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cause |=> (state == SRW_ACT))
        else $error("cause did not force active state");

    a_mr_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        mr_act |=> !reset_n)
        else $error("reset released during manual reset");

    a_mr_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
        mr_sync[1] |=> !mr_act)
        else $error("manual reset stuck after release");

    a_sup_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (supply_low && !sup_low_q) |=> (sup_low_q || sup_cnt == cnt_inc($past(sup_cnt))))
        else $error("supply filter did not count");

    a_sup_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !supply_low |=> !sup_low_q)
        else $error("supply low flag stuck");

    // Watchdog timer stepping and expiry
    a_wdt_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_RUN && !cause && !kick_edge && wdt_cnt < CNT_W'(WDT_CYC - 1))
        |=> (wdt_cnt == cnt_inc($past(wdt_cnt))))
        else $error("watchdog counter skipped");

    a_wdt_expire: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state == SRW_RUN && !cause && !kick_edge && wdt_cnt == CNT_W'(WDT_CYC - 1)) |=> wdt_fire)
        else $error("watchdog did not expire");

    a_fire_drops: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wdt_fire |=> !reset_n)
        else $error("expiry did not assert reset");

    a_wdt_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state != SRW_RUN) |=> !wdt_fire)
        else $error("watchdog fired while held");

    // First edge after release still shows reset values, so skip it
    a_kick_phase: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $past(arst_n) |-> (watchdog_kick_out == ($past(wdt_cnt) >= CNT_W'((WDT_CYC / 8) * 7 - 4))))
        else $error("internal kick phase wrong");

    a_oe_follow: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $past(arst_n) |-> (watchdog_kick_oe == !$past(watchdog_kick_oe_in)))
        else $error("internal driver enable wrong");

endmodule : srw_supervisor

// File: testbench/srw_cpu_model.sv
`timescale 1ns/1ps
module srw_cpu_model (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic kick_en,
    input  wire logic [31:0] kick_gap,
    output logic      kick_drive
);
    int cnt;

    // Processor held in reset does not run code, so it cannot kick
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt        <= 0;
            kick_drive <= 1'b0;
        end else if (kick_en) begin
            cnt        <= (cnt == kick_gap + 2) ? 0 : cnt + 1;
            kick_drive <= (cnt >= kick_gap);
        end
    end
endmodule : srw_cpu_model

// File: testbench/srw_supervisor_tb.sv
`timescale 1ns/1ps
module srw_supervisor_tb;
    import srw_pkg::*;
    localparam int HOLD = 100;
    localparam int WDT  = 400;
    typedef struct {bit mr; int width; logic hit;} srw_row_s;
    logic     clk_sys, arst_n, supply_low, manual_reset_n, pin, dut_out, dut_oe, reset_n, reset_hi;
    logic     cpu_drv, cpu_oe, kick_en;
    int       fail_count, cmp_count, k;
    srw_row_s rows [6] = '{'{1, 10, 0}, '{1, 40, 0}, '{1, 60, 1}, '{1, 150, 1}, '{0, 3, 0}, '{0, 30, 1}};

    // Pin level: processor drives when enabled, otherwise the internal driver
    assign pin = cpu_oe ? cpu_drv : dut_out;

    srw_supervisor #(.MR_EN(1'b1), .HOLD_CYC(HOLD), .WDT_CYC(WDT), .SUP_DLY_CYC(5)) u_srw_supervisor (
        .clk_sys(clk_sys), .arst_n(arst_n), .supply_low(supply_low), .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(pin), .watchdog_kick_oe_in(cpu_oe), .watchdog_kick_out(dut_out),
        .watchdog_kick_oe(dut_oe), .reset_n(reset_n), .reset_hi(reset_hi));
    srw_cpu_model u_srw_cpu_model (.clk_sys(clk_sys), .reset_n(reset_n), .kick_en(kick_en),
        .kick_gap(WDT - 20), .kick_drive(cpu_drv));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task check(input string what, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    task wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task wait_level(input logic lvl, input int lim, output int n);
        n = 0;
        while (reset_n !== lvl) begin
            if (n == lim) begin
                fail_count++;
                $display("wrong value reset_n wait expected %b seen %b", lvl, reset_n);
                wrap_up();
            end
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : wait_level

    task quiet(input int cycles, output logic seen);
        seen = 1'b0;
        repeat (cycles) begin
            @(posedge clk_sys);
            #1;
            if (reset_n !== 1'b1) seen = 1'b1;
        end
    endtask : quiet

    task run_cause(input bit mr, input int width, input logic hit);
        logic seen;
        logic late;
        if (mr) manual_reset_n = 1'b0;
        else supply_low = 1'b1;
        quiet(width, seen);
        manual_reset_n = 1'b1;
        supply_low     = 1'b0;
        quiet(1, late);
        check("reset asserted", seen, hit);
        if (hit) begin
            wait_level(1'b1, HOLD + 50, k);
            check("hold length", k >= HOLD - 1 && k <= HOLD + 8, 1'b1);
        end else begin
            quiet(70, seen);
            check("short pulse ignored", seen | late, 1'b0);
        end
    endtask : run_cause

    // Registered outputs must never disagree, also during reset
    always @(negedge clk_sys) check("reset_hi", reset_hi, ~reset_n);

    initial begin
        logic seen;
        fail_count = 0; cmp_count = 0; arst_n = 1'b0; supply_low = 1'b0;
        manual_reset_n = 1'b1; cpu_oe = 1'b1; kick_en = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        check("reset_n in reset", reset_n, 1'b0);
        check("kick oe in reset", dut_oe, 1'b0);
        arst_n = 1'b1;
        wait_level(1'b1, HOLD + 50, k);
        check("power-up hold", k >= HOLD && k <= HOLD + 8, 1'b1);
        $display("test power-up done");
        foreach (rows[i]) run_cause(rows[i].mr, rows[i].width, rows[i].hit);
        $display("test cause table done");
        supply_low = 1'b1;
        quiet(20, seen);
        supply_low = 1'b0;
        quiet(40, seen);
        run_cause(1'b0, 20, 1'b1);
        $display("test brownout restart done");
        quiet(20, seen);
        quiet(3 * WDT, seen);
        check("kicked watchdog quiet", seen, 1'b0);
        $display("test kicking done");
        kick_en = 1'b0;
        wait_level(1'b0, 2 * WDT, k);
        wait_level(1'b1, HOLD + 50, k);
        check("expiry pulse", k >= HOLD && k <= HOLD + 4, 1'b1);
        wait_level(1'b0, WDT + 50, k);
        check("timeout length", k >= WDT - 2 && k <= WDT + 4, 1'b1);
        wait_level(1'b1, HOLD + 50, k);
        $display("test watchdog expiry done");
        cpu_oe = 1'b0;
        quiet(3 * WDT, seen);
        check("undriven kick quiet", seen, 1'b0);
        check("internal driver on", dut_oe, 1'b1);
        $display("test undriven kick done");
        arst_n = 1'b0;
        #1;
        check("mid-run reset", reset_n, 1'b0);
        @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        wait_level(1'b1, HOLD + 50, k);
        check("second power-up hold", k >= HOLD && k <= HOLD + 8, 1'b1);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule : srw_supervisor_tb
